// [hw/pdas_regs.vh]
// Register offsets, field positions, reset values and command codes of the DMA abort block
`ifndef PDAS_REGS_VH
`define PDAS_REGS_VH

// ----------------------------------------------------------------
// Configuration space (one copy per function)
// ----------------------------------------------------------------
`define PDAS_CFG_STATUS_OFF 8'h04
`define PDAS_CFG_INTPIN_OFF 8'h3c
`define PDAS_CFG_STATUS_LSB 16
`define PDAS_RX_TARGET_ABORT_FLAG_BIT 12
`define PDAS_RX_MASTER_ABORT_FLAG_BIT 13
`define PDAS_LAN_INTPIN_RST 8'h02
`define PDAS_SCSI_INTPIN_RST 8'h01

// ----------------------------------------------------------------
// SCSI DMA registers in I/O space
// ----------------------------------------------------------------
`define PDAS_DMA_CMD_OFF 8'h40
`define PDAS_DMA_CNT_OFF 8'h44
`define PDAS_DMA_STATUS_OFF 8'h54
`define PDAS_DMA_BUSY_BIT 0
`define PDAS_DMA_ABORT_BIT 2
`define PDAS_DMA_DONE_BIT 3
`define PDAS_CNT_RST 16'h0000

// ----------------------------------------------------------------
// DMA command field codes
// ----------------------------------------------------------------
`define PDAS_CMD_IDLE 2'h0
`define PDAS_CMD_DRAIN 2'h1
`define PDAS_CMD_START 2'h2
`define PDAS_CMD_ABORT 2'h3

`endif

// [hw/pdas_fifo.v]
// Small synchronous FIFO between the SCSI core and the DMA bus master
module pdas_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clk,
    input wire i_rst,
    input wire [WIDTH-1:0] i_in_data,
    input wire i_in_valid,
    output reg o_in_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire o_out_valid,
    input wire i_out_ready
);
    // ----------------------------------------------------------------
    // Storage and pointers
    // ----------------------------------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Word storage
    reg [AW-1:0] wr_ptr_ff; // Next slot to fill
    reg [AW-1:0] rd_ptr_ff; // Oldest word
    reg [AW:0] count_ff; // Words held
    reg [AW:0] nxt_count;
    wire push;
    wire pop;

    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;
    assign o_out_valid = (count_ff != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr_ff];

    // Occupancy after this cycle
    always @* begin
        nxt_count = count_ff;
        if (push & ~pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop & ~push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    // Ready is registered so the source never sees a combinational path
    always @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            o_in_ready <= 1'b0;
        end else begin
            if (push) begin
                mem[wr_ptr_ff] <= i_in_data;
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            o_in_ready <= (nxt_count != DEPTH[AW:0]);
        end
    end
endmodule // pdas_fifo

// [hw/pdas_top.v]
// SCSI DMA master with abort reporting, two config spaces and bus parking
//
// Function
// - Park: drive AD, C/BE, PAR on idle grant
// - Slave access is single cycle, 8/16/32 bits
// - Target abort sets DMA abort, no interrupt
// - Target abort sets function status bit 12
// - Master abort sets DMA abort, no interrupt
// - Master abort sets function status bit 13
// - Two-bit command: idle, drain, start, abort
// - Idle command stops, keeps status, no interrupt
// - LAN interrupt pin reads 02h after reset
// - Config cycle claimed only with select active
// - First select SCSI space, second LAN space
// - SCSI irq first output, LAN second
// - Separate request/grant pair per function
`include "pdas_regs.vh"
module pdas_top #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_acc_valid,
    input wire i_acc_cfg,
    input wire i_acc_write,
    input wire [7:0] i_acc_addr,
    input wire [3:0] i_acc_be,
    input wire [31:0] i_acc_wdata,
    output reg o_acc_ack,
    output reg o_acc_claimed,
    output reg [31:0] o_acc_rdata,
    input wire i_scsi_cfg_select,
    input wire i_lan_cfg_select,
    input wire i_scsi_bus_grant,
    input wire i_lan_bus_grant,
    input wire i_bus_idle,
    input wire i_scsi_target_abort,
    input wire i_scsi_master_abort,
    output reg o_scsi_bus_request,
    output reg o_lan_bus_request,
    input wire i_lan_xfer_req,
    input wire i_lan_target_abort,
    input wire i_lan_master_abort,
    input wire i_lan_irq_req,
    input wire [31:0] i_dma_wdata,
    input wire i_dma_wvalid,
    output wire o_dma_wready,
    output reg [31:0] o_ad_out,
    output reg o_ad_oe,
    output reg [3:0] o_cbe_out,
    output reg o_cbe_oe,
    output reg o_par_out,
    output reg o_par_oe,
    output reg o_scsi_irq_out_n,
    output reg o_scsi_irq_oe,
    output reg o_lan_irq_out_n,
    output reg o_lan_irq_oe
);
    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'h0; // No transfer
    localparam ST_XFER = 2'h1; // Counted transfer
    localparam ST_DRAIN = 2'h2; // Empty the FIFO, then finish
    localparam P_SSEL = 0; // Pin positions in the synchroniser
    localparam P_LSEL = 1;
    localparam P_SGNT = 2;
    localparam P_LGNT = 3;
    localparam P_IDLE = 4;
    localparam P_TABT = 5;
    localparam P_MABT = 6;

    // Sticky flag: set wins over a clear in the same cycle
    function rw1c;
        input cur;
        input set;
        input clr;
        begin
            rw1c = set | (cur & ~clr);
        end
    endfunction

    // Even parity over AD and C/BE
    function par_of;
        input [31:0] ad;
        input [3:0] cbe;
        begin
            par_of = ^{ad, cbe};
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [6:0] pin_s1_ff; // First stage, read only by the second
    reg [6:0] pin_s2_ff; // Stable copy
    reg [1:0] abt_prev_ff; // Previous abort levels for edge detect
    wire sel_scsi = pin_s2_ff[P_SSEL];
    wire sel_lan = pin_s2_ff[P_LSEL];
    wire grant_s = pin_s2_ff[P_SGNT];
    wire bus_idle = pin_s2_ff[P_IDLE];
    wire tabt_evt = pin_s2_ff[P_TABT] & ~abt_prev_ff[0];
    wire mabt_evt = pin_s2_ff[P_MABT] & ~abt_prev_ff[1];

    // Pins come from the PCI side, so they pass two stages
    always @(posedge i_clk) begin
        if (i_rst) begin
            pin_s1_ff <= 7'h00;
            pin_s2_ff <= 7'h00;
            abt_prev_ff <= 2'h0;
        end else begin
            pin_s1_ff <= {i_scsi_master_abort, i_scsi_target_abort, i_bus_idle,
                          i_lan_bus_grant, i_scsi_bus_grant, i_lan_cfg_select,
                          i_scsi_cfg_select};
            pin_s2_ff <= pin_s1_ff;
            abt_prev_ff <= pin_s2_ff[P_MABT:P_TABT];
        end
    end

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    reg [1:0] state_ff; // DMA state
    reg [1:0] nxt_state;
    reg [1:0] cmd_ff; // Last command written
    reg [15:0] count_ff; // Programmed word count
    reg [15:0] remain_ff; // Words left in transfer
    reg [15:0] nxt_remain;
    reg dma_abort_ff; // DMA status abort flag
    reg dma_done_ff; // DMA status done flag
    reg s_rt_ff; // SCSI config: received target abort
    reg s_rm_ff; // SCSI config: received master abort
    reg l_rt_ff; // LAN config: received target abort
    reg l_rm_ff; // LAN config: received master abort
    reg [31:0] nxt_rdata;
    reg set_abort;
    reg set_done;
    wire is_io = ~i_acc_cfg;
    wire cfg_s = i_acc_cfg & sel_scsi;
    wire cfg_l = i_acc_cfg & ~sel_scsi & sel_lan;
    wire wr = i_acc_valid & i_acc_write;
    wire rd = i_acc_valid & ~i_acc_write;
    wire cmd_wr = wr & is_io & (i_acc_addr == `PDAS_DMA_CMD_OFF) & i_acc_be[0];
    wire stat_rd = rd & is_io & (i_acc_addr == `PDAS_DMA_STATUS_OFF);
    wire cfg_clr = wr & (i_acc_addr == `PDAS_CFG_STATUS_OFF) & i_acc_be[3];
    wire clr_rt = i_acc_wdata[`PDAS_CFG_STATUS_LSB + `PDAS_RX_TARGET_ABORT_FLAG_BIT];
    wire clr_rm = i_acc_wdata[`PDAS_CFG_STATUS_LSB + `PDAS_RX_MASTER_ABORT_FLAG_BIT];
    wire [7:0] dma_stat = {4'h0, dma_done_ff, dma_abort_ff, 1'b0,
                           (state_ff != ST_IDLE)};

    // Read mux: unmapped offsets and unclaimed config cycles read zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (is_io) begin
            if (i_acc_addr == `PDAS_DMA_CMD_OFF) begin
                nxt_rdata = {30'h0000_0000, cmd_ff};
            end else if (i_acc_addr == `PDAS_DMA_CNT_OFF) begin
                nxt_rdata = {remain_ff, count_ff};
            end else if (i_acc_addr == `PDAS_DMA_STATUS_OFF) begin
                nxt_rdata = {24'h00_0000, dma_stat};
            end
        end else if (cfg_s) begin
            if (i_acc_addr == `PDAS_CFG_STATUS_OFF) begin
                nxt_rdata = {2'h0, s_rm_ff, s_rt_ff, 28'h000_0000};
            end else if (i_acc_addr == `PDAS_CFG_INTPIN_OFF) begin
                nxt_rdata = {16'h0000, `PDAS_SCSI_INTPIN_RST, 8'h00};
            end
        end else if (cfg_l) begin
            if (i_acc_addr == `PDAS_CFG_STATUS_OFF) begin
                nxt_rdata = {2'h0, l_rm_ff, l_rt_ff, 28'h000_0000};
            end else if (i_acc_addr == `PDAS_CFG_INTPIN_OFF) begin
                nxt_rdata = {16'h0000, `PDAS_LAN_INTPIN_RST, 8'h00};
            end
        end
    end

    // Every access is answered on the next edge; no bursts exist
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_acc_ack <= 1'b0;
            o_acc_claimed <= 1'b0;
            o_acc_rdata <= 32'h0000_0000;
        end else begin
            o_acc_ack <= i_acc_valid;
            o_acc_claimed <= i_acc_valid & (is_io | cfg_s | cfg_l);
            o_acc_rdata <= rd ? nxt_rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // FIFO and DMA state machine
    // ----------------------------------------------------------------
    wire [31:0] f_data;
    wire f_valid;
    wire abort_evt = tabt_evt | mabt_evt;
    wire active = (state_ff != ST_IDLE);
    wire beat = active & grant_s & f_valid & ~abort_evt & ~cmd_wr;

    pdas_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_data(i_dma_wdata),
        .i_in_valid(i_dma_wvalid),
        .o_in_ready(o_dma_wready),
        .o_out_data(f_data),
        .o_out_valid(f_valid),
        .i_out_ready(beat)
    );

    // Next state, remaining count and flag events
    always @* begin
        nxt_state = state_ff;
        nxt_remain = remain_ff;
        set_abort = 1'b0;
        set_done = 1'b0;
        if (abort_evt & active) begin
            nxt_state = ST_IDLE;
            set_abort = 1'b1;
        end else if (cmd_wr) begin
            case (i_acc_wdata[1:0])
                `PDAS_CMD_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                `PDAS_CMD_DRAIN: begin
                    if (active) begin
                        nxt_state = ST_DRAIN;
                    end
                end
                `PDAS_CMD_START: begin
                    if (count_ff != 16'h0000) begin
                        nxt_state = ST_XFER;
                        nxt_remain = count_ff;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    set_abort = active;
                end
            endcase
        end else if (beat) begin
            nxt_remain = remain_ff - 16'h0001;
            if ((state_ff == ST_XFER) & (remain_ff == 16'h0001)) begin
                nxt_state = ST_IDLE;
                set_done = 1'b1;
            end
        end else if ((state_ff == ST_DRAIN) & ~f_valid) begin
            nxt_state = ST_IDLE;
            set_done = 1'b1;
        end
    end

    // Registers; a status read clears the flags unless set this cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            cmd_ff <= `PDAS_CMD_IDLE;
            count_ff <= `PDAS_CNT_RST;
            remain_ff <= `PDAS_CNT_RST;
            dma_abort_ff <= 1'b0;
            dma_done_ff <= 1'b0;
            s_rt_ff <= 1'b0;
            s_rm_ff <= 1'b0;
            l_rt_ff <= 1'b0;
            l_rm_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            remain_ff <= nxt_remain;
            if (cmd_wr) begin
                cmd_ff <= i_acc_wdata[1:0];
            end
            // Count write honours byte lanes 0 and 1
            if (wr & is_io & (i_acc_addr == `PDAS_DMA_CNT_OFF)) begin
                if (i_acc_be[0]) begin
                    count_ff[7:0] <= i_acc_wdata[7:0];
                end
                if (i_acc_be[1]) begin
                    count_ff[15:8] <= i_acc_wdata[15:8];
                end
            end
            dma_abort_ff <= rw1c(dma_abort_ff, set_abort, stat_rd);
            dma_done_ff <= rw1c(dma_done_ff, set_done, stat_rd);
            s_rt_ff <= rw1c(s_rt_ff, tabt_evt, cfg_s & cfg_clr & clr_rt);
            s_rm_ff <= rw1c(s_rm_ff, mabt_evt, cfg_s & cfg_clr & clr_rm);
            l_rt_ff <= rw1c(l_rt_ff, i_lan_target_abort,
                            cfg_l & cfg_clr & clr_rt);
            l_rm_ff <= rw1c(l_rm_ff, i_lan_master_abort,
                            cfg_l & cfg_clr & clr_rm);
        end
    end

    // ----------------------------------------------------------------
    // Bus drive, arbitration and interrupt pins
    // ----------------------------------------------------------------
    wire park = bus_idle & grant_s & ~o_scsi_bus_request & ~active;

    // Data beats and parking both drive the shared lines; parity follows
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_ad_out <= 32'h0000_0000;
            o_ad_oe <= 1'b0;
            o_cbe_out <= 4'h0;
            o_cbe_oe <= 1'b0;
            o_par_out <= 1'b0;
            o_par_oe <= 1'b0;
        end else if (beat) begin
            o_ad_out <= f_data;
            o_ad_oe <= 1'b1;
            o_cbe_out <= 4'h0;
            o_cbe_oe <= 1'b1;
            o_par_out <= par_of(f_data, 4'h0);
            o_par_oe <= 1'b1;
        end else if (park) begin
            o_ad_out <= 32'h0000_0000;
            o_ad_oe <= 1'b1;
            o_cbe_out <= 4'h0;
            o_cbe_oe <= 1'b1;
            o_par_out <= par_of(32'h0000_0000, 4'h0);
            o_par_oe <= 1'b1;
        end else begin
            o_ad_oe <= 1'b0;
            o_cbe_oe <= 1'b0;
            o_par_oe <= 1'b0;
        end
    end

    // Interrupt pins are open drain: low level, enable when asserted.
    // Aborts never reach the SCSI pin; only a finished transfer does.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_scsi_bus_request <= 1'b0;
            o_lan_bus_request <= 1'b0;
            o_scsi_irq_out_n <= 1'b0;
            o_scsi_irq_oe <= 1'b0;
            o_lan_irq_out_n <= 1'b0;
            o_lan_irq_oe <= 1'b0;
        end else begin
            o_scsi_bus_request <= (nxt_state != ST_IDLE);
            o_lan_bus_request <= i_lan_xfer_req;
            o_scsi_irq_out_n <= 1'b0;
            o_scsi_irq_oe <= rw1c(dma_done_ff, set_done, stat_rd);
            o_lan_irq_out_n <= 1'b0;
            o_lan_irq_oe <= i_lan_irq_req;
        end
    end
endmodule // pdas_top

// [sim/pdas_checker.sv]
// Concurrent checks on the ports of the DMA abort block
`include "pdas_regs.vh"
module pdas_checker (
    input logic i_clk,
    input logic i_rst,
    input logic i_acc_valid,
    input logic i_acc_cfg,
    input logic i_acc_write,
    input logic [7:0] i_acc_addr,
    input logic [3:0] i_acc_be,
    input logic [31:0] i_acc_wdata,
    input logic o_acc_ack,
    input logic o_acc_claimed,
    input logic i_scsi_cfg_select,
    input logic i_lan_cfg_select,
    input logic i_scsi_bus_grant,
    input logic i_bus_idle,
    input logic i_scsi_target_abort,
    input logic i_scsi_master_abort,
    input logic o_scsi_bus_request,
    input logic i_lan_xfer_req,
    input logic o_lan_bus_request,
    input logic i_lan_irq_req,
    input logic o_lan_irq_oe,
    input logic o_scsi_irq_oe,
    input logic o_ad_oe,
    input logic o_cbe_oe,
    input logic o_par_oe
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Command write seen on the register port
    wire cmd_wr = i_acc_valid & ~i_acc_cfg & i_acc_write & i_acc_be[0]
        & (i_acc_addr == `PDAS_DMA_CMD_OFF);
    // Stall with an empty FIFO keeps a finish out of these windows
    wire pin_abort = i_scsi_target_abort | i_scsi_master_abort;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    ack_one_cycle_a: assert property (
        i_acc_valid |=> o_acc_ack) else $error("ack missing after access");
    ack_no_stray_a: assert property (
        !i_acc_valid |=> !o_acc_ack) else $error("ack without access");
    unsel_cfg_refused_a: assert property (
        (!i_scsi_cfg_select && !i_lan_cfg_select)[*3] ##0 (i_acc_valid && i_acc_cfg)
        |=> !o_acc_claimed) else $error("unselected config cycle claimed");
    io_claimed_a: assert property (
        i_acc_valid && !i_acc_cfg |=> o_acc_claimed) else $error("io access not claimed");
    abort_no_irq_a: assert property (
        $rose(pin_abort) && o_scsi_bus_request && !o_scsi_irq_oe
        |=> !o_scsi_irq_oe [*6]) else $error("interrupt after abort");
    abort_stops_a: assert property (
        $rose(pin_abort) |-> ##[1:6] !o_scsi_bus_request) else $error("abort did not stop");
    lan_req_follow_a: assert property (
        1'h1 |=> o_lan_bus_request == $past(i_lan_xfer_req)) else $error("lan request lag");
    lan_irq_follow_a: assert property (
        i_lan_irq_req |=> o_lan_irq_oe) else $error("lan interrupt missing");
    park_drive_a: assert property (
        (i_bus_idle && i_scsi_bus_grant && !o_scsi_bus_request) [*5]
        |-> o_ad_oe && o_cbe_oe && o_par_oe) else $error("bus not parked");
    cmd_stop_a: assert property (
        cmd_wr && i_acc_wdata[1:0] == `PDAS_CMD_IDLE |-> ##[1:3] !o_scsi_bus_request)
        else $error("idle command did not stop");
    cmd_no_irq_a: assert property (
        cmd_wr && i_acc_wdata[1:0] == `PDAS_CMD_IDLE && !o_scsi_irq_oe
        |=> !o_scsi_irq_oe [*4]) else $error("idle command raised interrupt");
endmodule // pdas_checker

// [sim/pdas_host_model.sv]
// Arbiter and host side: grants, parking and abort injection
module pdas_host_model (
    input wire i_clk,
    input wire i_rst,
    input wire i_scsi_req,
    input wire i_lan_req,
    input wire i_park,
    input wire i_slow,
    input wire [1:0] i_abort,
    output logic o_scsi_gnt,
    output logic o_lan_gnt,
    output logic o_idle,
    output logic o_ta,
    output logic o_ma
);
    logic [2:0] wait_ff; // Cycles the SCSI request has waited
    // ----------------------------------------
    // Arbitration, slow mode delays the grant to stress the stall path
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (i_rst) begin
            {wait_ff, o_scsi_gnt, o_lan_gnt, o_idle, o_ta, o_ma} <= 8'h00;
        end else begin
            wait_ff <= i_scsi_req ? wait_ff + {2'h0, wait_ff != 3'h7} : 3'h0;
            // Grant without request only while parking the idle bus
            o_scsi_gnt <= i_park | (i_scsi_req & (wait_ff >= (i_slow ? 3'h5 : 3'h1)));
            o_lan_gnt <= i_lan_req;
            o_idle <= i_park;
            // Aborts only when the bench commands them
            o_ta <= i_abort == 2'h1;
            o_ma <= i_abort == 2'h2;
        end
    end
endmodule // pdas_host_model

// [sim/test_pci_dma_abort_status.sv]
// Self-checking bench: config spaces, parking, DMA beats, aborts, commands
`include "pdas_regs.vh"
module test_pci_dma_abort_status;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals, named as the ports so the block connects by name
    // ----------------------------------------
    localparam int DEPTH = 4; // FIFO words
    logic i_clk = 1'h0, i_rst = 1'h1, i_acc_valid = 1'h0, i_acc_cfg = 1'h0, i_acc_write = 1'h0;
    logic [7:0] i_acc_addr = 8'h00;
    logic [3:0] i_acc_be = 4'h0;
    logic [31:0] i_acc_wdata = 32'h0, i_dma_wdata = 32'h0, rd, exp_w;
    logic i_scsi_cfg_select = 1'h0, i_lan_cfg_select = 1'h0, i_dma_wvalid = 1'h0;
    logic i_lan_xfer_req = 1'h0, i_lan_target_abort = 1'h0, i_lan_master_abort = 1'h0;
    logic i_lan_irq_req = 1'h0, park = 1'h0, slow = 1'h0, claimed, beat_on = 1'h0;
    logic [1:0] abort_kind = 2'h0;
    wire i_scsi_bus_grant, i_lan_bus_grant, i_bus_idle, i_scsi_target_abort, i_scsi_master_abort;
    wire o_acc_ack, o_acc_claimed, o_scsi_bus_request, o_lan_bus_request, o_dma_wready;
    wire o_ad_oe, o_cbe_oe, o_par_out, o_par_oe, o_scsi_irq_out_n, o_scsi_irq_oe;
    wire o_lan_irq_out_n, o_lan_irq_oe;
    wire [31:0] o_acc_rdata, o_ad_out;
    wire [3:0] o_cbe_out;
    wire scsi_irq_line_n = o_scsi_irq_oe ? o_scsi_irq_out_n : 1'h1; // Pulled up when released
    int n_mismatch = 0, cmp_count = 0;
    logic [31:0] seed = 32'hf574bdfa;
    logic [31:0] exq[$]; // Words the FIFO accepted, in order
    pdas_top #(.FIFO_DEPTH(DEPTH)) dut (.*);
    pdas_host_model far_end (.i_clk(i_clk), .i_rst(i_rst), .i_scsi_req(o_scsi_bus_request),
        .i_lan_req(o_lan_bus_request), .i_park(park), .i_slow(slow), .i_abort(abort_kind),
        .o_scsi_gnt(i_scsi_bus_grant), .o_lan_gnt(i_lan_bus_grant), .o_idle(i_bus_idle),
        .o_ta(i_scsi_target_abort), .o_ma(i_scsi_master_abort));
    initial forever #12.5 i_clk = ~i_clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One access; valid stands a single cycle, answer looked at the next
    task automatic acc(logic c, logic w, logic [7:0] a, logic [3:0] b, logic [31:0] d);
        @(negedge i_clk);
        {i_acc_valid, i_acc_cfg, i_acc_write} = {1'h1, c, w};
        {i_acc_addr, i_acc_be, i_acc_wdata} = {a, b, d};
        @(negedge i_clk);
        i_acc_valid = 1'h0;
        chk("ack", 1, o_acc_ack);
        rd = o_acc_rdata;
        claimed = o_acc_claimed;
    endtask
    // Selects are synchronised, so hold them a few cycles first
    task automatic cfg_rd(logic lan, logic [7:0] a);
        {i_lan_cfg_select, i_scsi_cfg_select} = {lan, !lan};
        repeat (4) @(negedge i_clk);
        acc(1'h1, 1'h0, a, 4'hf, 32'h0);
    endtask
    task automatic st_rd();
        acc(1'h0, 1'h0, `PDAS_DMA_STATUS_OFF, 4'hf, 32'h0);
    endtask
    task automatic start(logic [15:0] cnt);
        acc(1'h0, 1'h1, `PDAS_DMA_CNT_OFF, 4'h3, {16'h0, cnt});
        acc(1'h0, 1'h1, `PDAS_DMA_CMD_OFF, 4'h1, {30'h0, `PDAS_CMD_START});
    endtask
    task automatic push(logic [31:0] d);
        @(negedge i_clk);
        {i_dma_wvalid, i_dma_wdata} = {1'h1, d};
        if (o_dma_wready === 1'h1) exq.push_back(d);
        @(negedge i_clk);
        i_dma_wvalid = 1'h0;
    endtask
    // Each driven beat must carry the next accepted word
    always @(posedge i_clk) begin
        if (beat_on && o_ad_oe === 1'h1) begin
            exp_w = exq.size() ? exq.pop_front() : 32'hx;
            chk("beat data", exp_w, o_ad_out);
        end
    end
    task automatic final_report();
        $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge i_clk);
        i_rst = 1'h0;
        // Two spaces, each behind its own select, refused when unselected
        cfg_rd(1'h1, `PDAS_CFG_INTPIN_OFF);
        chk("lan intpin", 8'h02, rd[15:8]);
        cfg_rd(1'h0, `PDAS_CFG_INTPIN_OFF);
        chk("scsi intpin", `PDAS_SCSI_INTPIN_RST, rd[15:8]);
        {i_lan_cfg_select, i_scsi_cfg_select} = 2'h0;
        repeat (4) @(negedge i_clk);
        acc(1'h1, 1'h0, `PDAS_CFG_INTPIN_OFF, 4'hf, 32'h0);
        chk("unselected claim", 0, claimed);
        chk("unselected data", 0, rd);
        $display("test config done");
        park = 1'h1;
        repeat (6) @(negedge i_clk);
        chk("park drive", 3'h7, {o_ad_oe, o_cbe_oe, o_par_oe});
        park = 1'h0;
        repeat (4) @(negedge i_clk);
        $display("test parking done");
        // Drain while idle and a zero count are both ignored
        acc(1'h0, 1'h1, `PDAS_DMA_CMD_OFF, 4'h1, {30'h0, `PDAS_CMD_DRAIN});
        start(16'h0);
        repeat (3) @(negedge i_clk);
        chk("zero count request", 0, o_scsi_bus_request);
        beat_on = 1'h1;
        for (int k = 0; k < DEPTH + 2; k++) push(rnd());
        chk("fifo fill", DEPTH, exq.size());
        slow = 1'h1;
        start(DEPTH);
        for (int k = 0; k < 300 && o_scsi_irq_oe !== 1'h1; k++) @(negedge i_clk);
        @(negedge i_clk);
        chk("beats left", 0, exq.size());
        chk("scsi irq line", 0, scsi_irq_line_n);
        chk("lan irq", 0, o_lan_irq_oe);
        st_rd();
        chk("done status", 3'h4, {rd[`PDAS_DMA_DONE_BIT], rd[`PDAS_DMA_ABORT_BIT], rd[0]});
        @(negedge i_clk);
        chk("irq after read", 0, o_scsi_irq_oe);
        $display("test transfer done");
        // Target then master abort in mid-transfer
        slow = 1'h0;
        for (int k = 1; k < 3; k++) begin
            push(rnd());
            push(rnd());
            start(16'h8);
            repeat (20) @(negedge i_clk);
            abort_kind = k[1:0];
            repeat (4) @(negedge i_clk);
            abort_kind = 2'h0;
            repeat (4) @(negedge i_clk);
            chk("abort irq", 0, o_scsi_irq_oe);
            chk("abort request", 0, o_scsi_bus_request);
            st_rd();
            chk("abort flag", 1, rd[`PDAS_DMA_ABORT_BIT]);
            st_rd();
            chk("abort flag read", 0, rd[`PDAS_DMA_ABORT_BIT]);
            cfg_rd(1'h0, `PDAS_CFG_STATUS_OFF);
            chk("scsi cfg flags", k, rd[`PDAS_CFG_STATUS_LSB + `PDAS_RX_TARGET_ABORT_FLAG_BIT +: 2]);
            acc(1'h1, 1'h1, `PDAS_CFG_STATUS_OFF, 4'h8, 32'h3000_0000);
        end
        $display("test aborts done");
        // Idle and abort commands while the engine waits on an empty FIFO
        for (int k = 0; k < 2; k++) begin
            start(16'h8);
            repeat (10) @(negedge i_clk);
            acc(1'h0, 1'h1, `PDAS_DMA_CMD_OFF, 4'h1, k ? `PDAS_CMD_ABORT : `PDAS_CMD_IDLE);
            repeat (3) @(negedge i_clk);
            chk("cmd stop", 0, {o_scsi_bus_request, o_scsi_irq_oe});
            st_rd();
            chk("cmd status", k ? 3'h2 : 3'h0, {rd[3:2], rd[0]});
        end
        $display("test commands done");
        // Ethernet side uses its own request, interrupt and flags
        {i_lan_xfer_req, i_lan_irq_req, i_lan_target_abort} = 3'h7;
        @(negedge i_clk);
        {i_lan_target_abort, i_lan_master_abort} = 2'h1;
        @(negedge i_clk);
        i_lan_master_abort = 1'h0;
        chk("lan pins", 4'hc, {o_lan_bus_request, o_lan_irq_oe, o_scsi_bus_request, o_scsi_irq_oe});
        cfg_rd(1'h1, `PDAS_CFG_STATUS_OFF);
        chk("lan cfg flags", 2'h3, rd[`PDAS_CFG_STATUS_LSB + `PDAS_RX_TARGET_ABORT_FLAG_BIT +: 2]);
        cfg_rd(1'h0, `PDAS_CFG_STATUS_OFF);
        chk("scsi cfg kept", 2'h0, rd[`PDAS_CFG_STATUS_LSB + `PDAS_RX_TARGET_ABORT_FLAG_BIT +: 2]);
        {i_lan_xfer_req, i_lan_irq_req} = 2'h0;
        $display("test lan done");
        final_report();
    end
endmodule // test_pci_dma_abort_status
bind pdas_top pdas_checker checker_i (.*);
